/* rtl/flash_ctrl.sv */
// Host-side controller that drives a parallel flash through its pins.
// Assumes an AHB-Lite master on hclk and one flash with a push-pull
// ready/busy output; the bench resolves the data bus from the enable.
`timescale 1ns/1ps
`include "flash_ctrl_defs.svh"

module flash_ctrl (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic flash_ce_n,
   output logic flash_we_n,
   output logic flash_oe_n,
   output logic [15:0] flash_dq_o,
   output logic flash_dq_oe,
   input wire logic [15:0] flash_dq_i,
   output logic reset_powerdown_n,
   input wire logic ready_busy_out,
   input wire logic supply_good_signal
);

   // ****************************************************************
   // State registers
   // ****************************************************************
   flash_ctrl_pkg::ctrl_state_t r; // Registered state
   flash_ctrl_pkg::ctrl_state_t n; // Next state
   logic [15:0] we_last; // Last cycle of the write pulse
   logic [15:0] gap_last; // Last cycle of the recovery gap
   logic [15:0] oe_last; // Last cycle of a status read

   assign we_last = 16'(`WE_CYC - 1);
   assign gap_last = 16'(`GAP_CYC - 1);
   assign oe_last = 16'(`OE_CYC - 1);

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   // Bus slave, pin synchronisers and command sequencer
   always_comb begin
      n = r;
      // Two-flop synchronisers for pins
      n.sg_s1 = supply_good_signal;
      n.sg_s2 = r.sg_s1;
      n.rb_s1 = ready_busy_out;
      n.rb_s2 = r.rb_s1;
      n.dq_s1 = flash_dq_i[7:0];
      n.dq_s2 = r.dq_s1;
      // Reset pin low on supply loss or power-down request
      n.rp_n = r.sg_s2 & ~r.pd;
      // Wake delays counted from reset release
      if (!r.rp_n) begin
         n.wake = 16'h0000;
         n.rd_ok = 1'b0;
         n.wr_ok = 1'b0;
      end else begin
         if (r.wake != 16'hFFFF) begin
            n.wake = r.wake + 16'h0001;
         end
         n.rd_ok = r.wake >= 16'(`WAKE_RD_CYC);
         n.wr_ok = r.wake >= 16'(`WAKE_WR_CYC);
      end

      // AHB address phase: latch, and prepare read data
      n.ap_wr = 1'b0;
      if (hsel && htrans[1] && hready) begin
         n.ap_wr = hwrite;
         n.ap_addr = haddr[3:0];
         case (haddr[3:0])
            `CTRL_OFF: begin
               n.hrdata = {28'h0000000, r.pd, 1'b0, r.op};
            end
            `STAT_OFF: begin
               n.hrdata = {25'h0000000, r.rej, r.aborted, r.done,
                  r.busy, r.rb_s2, r.rd_ok, r.wr_ok};
            end
            `SREG_OFF: begin
               n.hrdata = {24'h000000, r.sr};
            end
            `CMD_OFF: begin
               n.hrdata = {24'h000000, r.cmd};
            end
            default: begin
               n.hrdata = 32'h00000000;
            end
         endcase
      end

      // AHB data phase: register writes
      if (r.ap_wr) begin
         case (r.ap_addr)
            `CTRL_OFF: begin
               n.pd = hwdata[`CTRL_PD_BIT];
               if (hwdata[`CTRL_GO_BIT]) begin
                  if (r.busy || !r.wr_ok || hwdata[`CTRL_PD_BIT]) begin
                     n.rej = 1'b1;
                  end else begin
                     // New sequence from its first step
                     n.op = flash_ctrl_pkg::op_t'(hwdata[1:0]);
                     n.busy = 1'b1;
                     n.done = 1'b0;
                     n.aborted = 1'b0;
                     n.rej = 1'b0;
                     n.step = 3'h0;
                     n.st = flash_ctrl_pkg::ST_NEXT;
                  end
               end
            end
            `STAT_OFF: begin
               // Write one to clear the sticky flags
               if (hwdata[`ST_DONE_BIT]) begin
                  n.done = 1'b0;
               end
               if (hwdata[`ST_ABORT_BIT]) begin
                  n.aborted = 1'b0;
               end
               if (hwdata[`ST_REJ_BIT]) begin
                  n.rej = 1'b0;
               end
            end
            `CMD_OFF: begin
               n.cmd = hwdata[7:0];
            end
            default: begin
            end
         endcase
      end

      // Command sequencer
      n.cnt = r.cnt + 16'h0001;
      case (r.st)
         flash_ctrl_pkg::ST_IDLE: begin
            n.cnt = 16'h0000;
         end
         flash_ctrl_pkg::ST_NEXT: begin
            n.cnt = 16'h0000;
            n.st = flash_ctrl_pkg::ST_WRITE;
            case (r.op)
               flash_ctrl_pkg::OP_CLEAR: begin
                  case (r.step)
                     3'h0: n.dq_o = {8'h00, `CMD_LOCK_SETUP};
                     3'h1: n.dq_o = {8'h00, `CMD_CONFIRM};
                     3'h2: n.st = flash_ctrl_pkg::ST_READ;
                     3'h3: n.dq_o = {8'h00, `CMD_READ_ARRAY};
                     default: n.st = flash_ctrl_pkg::ST_IDLE;
                  endcase
               end
               flash_ctrl_pkg::OP_ARRAY: begin
                  n.dq_o = {8'h00, `CMD_READ_ARRAY};
                  if (r.step != 3'h0) begin
                     n.st = flash_ctrl_pkg::ST_IDLE;
                  end
               end
               flash_ctrl_pkg::OP_RAW: begin
                  n.dq_o = {8'h00, r.cmd};
                  if (r.step != 3'h0) begin
                     n.st = flash_ctrl_pkg::ST_IDLE;
                  end
               end
               default: begin
                  n.st = (r.step == 3'h0) ? flash_ctrl_pkg::ST_READ
                     : flash_ctrl_pkg::ST_IDLE;
               end
            endcase
            if (n.st == flash_ctrl_pkg::ST_IDLE) begin
               n.busy = 1'b0;
               n.done = 1'b1;
            end else if (n.st == flash_ctrl_pkg::ST_WRITE) begin
               // Both enables low only during the write pulse
               n.ce_n = 1'b0;
               n.we_n = 1'b0;
               n.dq_oe = 1'b1;
            end else begin
               // Read strobe only with the chip selected
               n.ce_n = 1'b0;
               n.oe_n = 1'b0;
            end
         end
         flash_ctrl_pkg::ST_WRITE: begin
            if (r.cnt == we_last) begin
               n.we_n = 1'b1;
               n.ce_n = 1'b1;
               n.cnt = 16'h0000;
               n.st = flash_ctrl_pkg::ST_GAP;
            end
         end
         flash_ctrl_pkg::ST_READ: begin
            if (r.cnt == oe_last) begin
               n.sr = r.dq_s2;
               n.oe_n = 1'b1;
               n.ce_n = 1'b1;
               n.cnt = 16'h0000;
               n.st = flash_ctrl_pkg::ST_GAP;
               // Keep polling while the flash reports busy
               if (r.op == flash_ctrl_pkg::OP_CLEAR &&
                   !r.dq_s2[`SR_READY_BIT]) begin
                  n.step = r.step - 3'h1;
               end
            end
         end
         flash_ctrl_pkg::ST_GAP: begin
            n.dq_oe = 1'b0;
            if (r.cnt == gap_last) begin
               n.step = r.step + 3'h1;
               n.st = flash_ctrl_pkg::ST_NEXT;
            end
         end
         default: begin
            n.st = flash_ctrl_pkg::ST_IDLE;
         end
      endcase

      // Reset pin low mid-sequence: drop it, flag for a full reissue
      if (!r.rp_n && r.busy) begin
         n.st = flash_ctrl_pkg::ST_IDLE;
         n.busy = 1'b0;
         n.done = 1'b0;
         n.aborted = 1'b1;
         n.ce_n = 1'b1;
         n.we_n = 1'b1;
         n.oe_n = 1'b1;
         n.dq_oe = 1'b0;
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   // All state, reset to idle with strobes inactive and the reset pin low
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= '0;
         r.st <= flash_ctrl_pkg::ST_IDLE;
         r.ce_n <= 1'b1;
         r.we_n <= 1'b1;
         r.oe_n <= 1'b1;
         r.hreadyout <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign hreadyout = r.hreadyout;
   assign hresp = 1'b0 & r.hreadyout;
   assign hrdata = r.hrdata;
   assign flash_ce_n = r.ce_n;
   assign flash_we_n = r.we_n;
   assign flash_oe_n = r.oe_n;
   assign flash_dq_o = r.dq_o;
   assign flash_dq_oe = r.dq_oe;
   assign reset_powerdown_n = r.rp_n;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   we_needs_ce_a: assert property (@(posedge hclk)
      disable iff (!hresetn) !r.we_n |-> !r.ce_n && r.oe_n && r.dq_oe)
      else $error("write strobe without chip enable or data drive");

   oe_select_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !r.oe_n |-> !r.ce_n && !r.dq_oe && r.we_n)
      else $error("read strobe without select or with bus driven");

   clear_setup_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(r.we_n) && r.op == flash_ctrl_pkg::OP_CLEAR && r.step == 3'h0
      |-> r.dq_o[7:0] == 8'h60)
      else $error("clear sequence did not start with setup");

   clear_confirm_a: assert property (@(posedge hclk)
      disable iff (!hresetn) $fell(r.we_n) && r.step == 3'h1 &&
      r.op == flash_ctrl_pkg::OP_CLEAR |-> r.dq_o[7:0] == 8'hD0)
      else $error("clear sequence confirm byte wrong");

   poll_ready_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(r.done) && r.op == flash_ctrl_pkg::OP_CLEAR
      |-> r.sr[7])
      else $error("clear sequence ended before status ready");

   array_after_a: assert property (@(posedge hclk)
      disable iff (!hresetn) $fell(r.we_n) && r.step == 3'h3 &&
      r.op == flash_ctrl_pkg::OP_CLEAR |-> r.dq_o[7:0] == 8'hFF)
      else $error("read-array command missing after clear");

   abort_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !r.rp_n && r.busy |=> !r.busy && r.aborted && r.ce_n && r.we_n)
      else $error("reset during sequence not flagged as abort");

   rp_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !r.sg_s2 |=> !r.rp_n)
      else $error("reset pin did not follow supply-good");

   wake_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(r.busy) |-> r.wr_ok && r.wake >= 16'(`WAKE_WR_CYC))
      else $error("sequence started before wake delay");

endmodule

/* rtl/flash_ctrl_defs.svh */
// Constants of the flash command and status controller.
// Assumes a 100 MHz hclk and one parallel flash on the far side.
// Operation
// - Clear lock bits: write 60H, then D0H
// - Poll status bit 7 until ready
// - Reissue whole sequence after an abort; the controller does not reissue, it only sets the aborted flag
// - Issue read-array before reading array again
// - Write only with write and chip enable low
// - Chip enable decoded, output enable read-only
// - Reset pin follows supply-good signal
// - Wait wake delays after reset release
`ifndef FLASH_CTRL_DEFS_SVH
`define FLASH_CTRL_DEFS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define CTRL_OFF 4'h0
`define STAT_OFF 4'h4
`define SREG_OFF 4'h8
`define CMD_OFF 4'hC
// Control fields
`define CTRL_OP_LSB 0
`define CTRL_GO_BIT 2
`define CTRL_PD_BIT 3
// Status fields
`define ST_WROK_BIT 0
`define ST_RDOK_BIT 1
`define ST_RB_BIT 2
`define ST_BUSY_BIT 3
`define ST_DONE_BIT 4
`define ST_ABORT_BIT 5
`define ST_REJ_BIT 6

// ****************************************************************
// Flash commands and status bits
// ****************************************************************
`define CMD_LOCK_SETUP 8'h60
`define CMD_CONFIRM 8'hD0
`define CMD_READ_ARRAY 8'hFF
`define SR_READY_BIT 7

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_NS 10
`define WE_PULSE_NS 100
`define WE_GAP_NS 50
`define OE_READ_NS 150
`define WAKE_READ_NS 600
`define WAKE_WRITE_NS 1000
`define WE_CYC ((`WE_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define GAP_CYC ((`WE_GAP_NS + `CLK_NS - 1) / `CLK_NS)
`define OE_CYC ((`OE_READ_NS + `CLK_NS - 1) / `CLK_NS)
`define WAKE_RD_CYC ((`WAKE_READ_NS + `CLK_NS - 1) / `CLK_NS)
`define WAKE_WR_CYC ((`WAKE_WRITE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

/* rtl/flash_ctrl_pkg.sv */
// Types of the flash command and status controller.
// Assumes flash_ctrl_defs.svh is on the include path.
`include "flash_ctrl_defs.svh"

package flash_ctrl_pkg;

   // ****************************************************************
   // Sequencer states and operations
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_NEXT = 3'h1,
      ST_WRITE = 3'h2,
      ST_GAP = 3'h3,
      ST_READ = 3'h4
   } seq_state_t;

   typedef enum logic [1:0] {
      OP_CLEAR = 2'h0,
      OP_ARRAY = 2'h1,
      OP_RAW = 2'h2,
      OP_STATUS = 2'h3
   } op_t;

   // ****************************************************************
   // Whole module state
   // ****************************************************************
   typedef struct packed {
      seq_state_t st;
      op_t op;
      logic [2:0] step;
      logic [15:0] cnt;
      logic [15:0] wake;
      logic [7:0] sr;
      logic [7:0] cmd;
      logic busy;
      logic done;
      logic aborted;
      logic rej;
      logic pd;
      logic rd_ok;
      logic wr_ok;
      logic ce_n;
      logic we_n;
      logic oe_n;
      logic dq_oe;
      logic [15:0] dq_o;
      logic rp_n;
      logic sg_s1;
      logic sg_s2;
      logic rb_s1;
      logic rb_s2;
      logic [7:0] dq_s1;
      logic [7:0] dq_s2;
      logic ap_wr;
      logic [3:0] ap_addr;
      logic [31:0] hrdata;
      logic hreadyout;
   } ctrl_state_t;

endpackage

/* sim/flash_dev_model.sv */
// Behavioural flash device: command latch, status byte, ready/busy.
// Assumes the bench resolves the shared data bus into dq_in.
`timescale 1ns/1ps

module flash_dev_model #(
   parameter int BUSY_NS = 2000,
   parameter int ABORT_NS = 100,
   parameter logic [15:0] ARRAY_WORD = 16'h5AC3
) (
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic [15:0] dq_in,
   output logic [15:0] dq_out,
   input wire logic rp_n,
   input wire logic vpp_low,
   input wire logic locked,
   output logic ready_busy_out
);
   // ****************************************************************
   // Device state
   // ****************************************************************
   logic busy = 1'b0; // Engine running
   logic stat_mode = 1'b0; // Reads give status, else array
   logic pend = 1'b0; // Setup byte seen
   logic [7:0] err = 8'h00; // Sticky error bits
   logic [15:0] last = 16'h0000; // Last value driven
   wire drv = !oe_n && !ce_n && rp_n;
   wire [15:0] cur = stat_mode ? {8'h00, ~busy, err[6:0]}
      : ARRAY_WORD;
   // Released bus shows the inverse of the last value
   assign dq_out = drv ? cur : ~last;
   assign ready_busy_out = ~busy;
   always @(negedge drv) last = cur;
   // Command latch, both enables low and out of reset
   always @(negedge we_n) begin
      #1;
      if (!ce_n && rp_n) begin
         if (pend) begin
            pend = 1'b0;
            stat_mode = 1'b1;
            if (dq_in[7:0] != 8'hD0) err = err | 8'h30;
            else if (vpp_low) err = err | 8'h28;
            // Protected part refuses the clear
            else if (locked) err = err | 8'h22;
            else busy = 1'b1;
         end else begin
            case (dq_in[7:0])
               8'h60: begin
                  pend = 1'b1;
                  stat_mode = 1'b1;
               end
               8'hFF: stat_mode = 1'b0;
               8'h70: stat_mode = 1'b1;
               8'h50: err = 8'h00;
               default: ;
            endcase
         end
      end
   end
   // Engine run time
   always begin
      wait (busy);
      #(BUSY_NS);
      busy = 1'b0;
   end
   // Reset clears status, busy held until abort completes
   always @(negedge rp_n) begin
      err = 8'h00;
      pend = 1'b0;
      stat_mode = 1'b0;
      if (busy) begin
         #(ABORT_NS);
         busy = 1'b0;
      end
   end
endmodule

/* sim/flash_command_status_control_test.sv */
// Bench for the flash controller: AHB tasks drive register sequences.
// Assumes flash_ctrl and flash_dev_model are compiled before it.
`timescale 1ns/1ps
`include "flash_ctrl_defs.svh"
`define CHECK(got, exp) begin \
   num_checks++; \
   if ((got) !== (exp)) begin \
      err_count++; \
      $display("BAD %0t: got %h exp %h", $time, got, exp); \
   end \
end

module flash_command_status_control_test;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, ce_n, we_n, oe_n, dq_oe, rp_n, rb;
   logic [31:0] hrdata, d;
   logic [15:0] dq_o, dq_dev;
   logic vpp_low = 1'b0;
   logic locked = 1'b0; // Far side lock protection
   logic sg = 1'b1; // Supply-good into the controller
   logic rb_low = 1'b0;
   logic [7:0] cmds[$];
   int err_count = 0;
   int num_checks = 0;
   int cycles = 0;
   wire [15:0] dq_bus = dq_oe ? dq_o : dq_dev;

   flash_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .flash_ce_n(ce_n),
      .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_dq_o(dq_o),
      .flash_dq_oe(dq_oe), .flash_dq_i(dq_bus),
      .reset_powerdown_n(rp_n), .ready_busy_out(rb),
      .supply_good_signal(sg));
   flash_dev_model i_flash (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
      .dq_in(dq_bus), .dq_out(dq_dev), .rp_n(rp_n), .vpp_low(vpp_low),
      .locked(locked), .ready_busy_out(rb));

   // ****************************************************************
   // Clock, monitors, timeout
   // ****************************************************************
   always #5 hclk = ~hclk;
   always @(negedge rb) rb_low = 1'b1;
   // Log each command byte sent to the flash
   always @(negedge we_n) begin
      #1;
      cmds.push_back(dq_bus[7:0]);
      `CHECK(ce_n, 1'b0)
   end
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 30000) begin
         err_count++;
         results();
      end
   end

   // ****************************************************************
   // Bus tasks
   // ****************************************************************
   task automatic xfer(input logic [3:0] a, input logic w,
      input logic [31:0] v);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {28'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= v;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      d = hrdata;
   endtask
   task automatic rd(input logic [3:0] a);
      xfer(a, 1'b0, 32'h0);
   endtask
   task automatic poll(input int b);
      for (int i = 0; i < 2000; i++) begin
         rd(`STAT_OFF);
         if (d[b] === 1'b1) break;
      end
      `CHECK(d[b], 1'b1)
   endtask
   // Start one operation, wait for done, clear done
   task automatic op(input logic [31:0] k);
      xfer(`CTRL_OFF, 1'b1, 32'h4 | k);
      poll(4);
      xfer(`STAT_OFF, 1'b1, 32'h10);
   endtask
   task automatic sreg(input logic [7:0] e);
      rd(`SREG_OFF);
      `CHECK(d[7:0], e)
   endtask
   task automatic results();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(4'h2, 1'b1, 32'hFFFFFFFF);
      rd(4'h2);
      `CHECK(d, 32'h0)
      `CHECK(hresp, 1'b0)
      // Early start is refused, nothing reaches the flash
      xfer(`CTRL_OFF, 1'b1, 32'h4);
      rd(`STAT_OFF);
      `CHECK(d[6], 1'b1)
      `CHECK(d[1:0], 2'b00)
      `CHECK(cmds.size(), 0)
      xfer(`STAT_OFF, 1'b1, 32'h40);
      rd(`STAT_OFF);
      `CHECK(d[6], 1'b0)
      poll(1);
      poll(0);
      `CHECK(rp_n, 1'b1)
      // Clear-lock sequence and polling
      xfer(`CTRL_OFF, 1'b1, 32'h4);
      rd(`STAT_OFF);
      `CHECK(d[3], 1'b1)
      poll(4);
      xfer(`STAT_OFF, 1'b1, 32'h10);
      `CHECK({cmds[0], cmds[1], cmds[2]}, 24'h60D0FF)
      `CHECK(rb_low, 1'b1)
      sreg(8'h80);
      // Read-array, raw and status operations
      cmds.delete();
      xfer(`CMD_OFF, 1'b1, 32'h70);
      for (int k = 1; k < 4; k++) op(k);
      `CHECK({cmds[0], cmds[1]}, 16'hFF70)
      sreg(8'h80);
      // Supply error during clear-lock
      vpp_low <= 1'b1;
      op(0);
      vpp_low <= 1'b0;
      sreg(8'hA8);
      // Broken two-write sequence
      xfer(`CMD_OFF, 1'b1, 32'h60);
      op(2);
      xfer(`CMD_OFF, 1'b1, 32'h12);
      op(2);
      op(3);
      sreg(8'hB8);
      // Power-down in mid-operation
      xfer(`CTRL_OFF, 1'b1, 32'h4);
      for (int i = 0; i < 300 && rb !== 1'b0; i++) @(posedge hclk);
      xfer(`CTRL_OFF, 1'b1, 32'h8);
      repeat (3) @(posedge hclk);
      `CHECK(rp_n, 1'b0)
      `CHECK(rb, 1'b0)
      rd(`STAT_OFF);
      `CHECK(d[5:3], 3'b100)
      `CHECK(d[2], 1'b0)
      repeat (30) @(posedge hclk);
      `CHECK(rb, 1'b1)
      rd(`CTRL_OFF);
      `CHECK(d, 32'h8)
      xfer(`CTRL_OFF, 1'b1, 32'h0);
      poll(0);
      op(3);
      sreg(8'hC3);
      xfer(`CMD_OFF, 1'b1, 32'h70);
      op(2);
      op(3);
      sreg(8'h80);
      // Locked clear attempt fails with protect and erase error
      locked <= 1'b1;
      op(0);
      locked <= 1'b0;
      sreg(8'hA2);
      // Supply loss pulls the reset pin low, wake delays restart
      sg <= 1'b0;
      repeat (4) @(posedge hclk);
      `CHECK(rp_n, 1'b0)
      rd(`STAT_OFF);
      `CHECK(d[1:0], 2'b00)
      sg <= 1'b1;
      poll(0);
      op(3);
      sreg(8'hC3);
      rd(`CMD_OFF);
      `CHECK(d, 32'h70)
      results();
   end
endmodule
